// ==== rtl/rtp_prescaler.v ====
// rtc prescaler, trim, clockwatch lock and two-source interrupt control
//
// Overview of operation
// R1 - one tick every divider plus one cycles
// R2 - divider zero: timer gets clock, clockwatch none
// R3 - trim deletes count pulses per 1023 cycles
// R4 - divider and trim frozen while clockwatch enabled
// R5 - bit 26 enables clockwatch counting ticks
// R6 - enabled: prescale register locked until reset
// R7 - mask bit 0 enables clockwatch interrupt
// R8 - mask bit 1 enables timer interrupt
// R9 - raw status shows unmasked pending bits
// R10 - masked status is raw and enable
// R11 - clear bit 0 clears clockwatch pending
// R12 - clear bit 1 clears timer pending
// R13 - lines follow masked bits; flags sticky
`include "rtp_regs.vh"
`default_nettype none

module rtp_prescaler
#(
  // divider and trim field widths
  parameter DIV_W  = 15,
  parameter TRIM_W = 10
)
(
  // clock and reset
  input  wire        clk_sys,
  input  wire        rst,
  // register port
  input  wire [7:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_write,
  input  wire        reg_read,
  output reg  [31:0] reg_rdata,
  // slow clock pin and derived ticks
  input  wire        slow_clock,
  output reg         one_second_tick,
  output reg         timer_tick,
  output reg         calendar_enable_lock,
  // events from clockwatch and timer logic
  input  wire        calendar_event,
  input  wire        timer_event,
  // interrupt lines
  output wire        calendar_irq_line,
  output wire        timer_irq_line,
  output reg         irq
);

  ////////////////////////////////////////////////////////////////////////////
  // slow clock synchroniser and edge detect

  reg        slow_meta;
  reg        slow_sync;
  reg        slow_prev;
  wire       slow_pulse;

  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      slow_meta <= 1'b0;
      slow_sync <= 1'b0;
      slow_prev <= 1'b0;
    end
    else
    begin
      slow_meta <= slow_clock;
      slow_sync <= slow_meta;
      slow_prev <= slow_sync;
    end
  end

  // only the second and third flops feed logic; the first may be metastable
  // the pin idles low, so prev resets low and no false edge follows reset
  assign slow_pulse = slow_sync & ~slow_prev;

  ////////////////////////////////////////////////////////////////////////////
  // register state

  reg [DIV_W-1:0]  tick_divider_factor;
  reg [TRIM_W-1:0] trim_delete_count;
  reg        calendar_irq_enable;
  reg        timer_irq_enable;
  wire       calendar_irq_raw;
  wire       timer_irq_raw;
  wire       calendar_irq_masked;
  wire       timer_irq_masked;
  wire       wr_prescale;
  wire       wr_mask;
  wire       wr_clear;
  wire       calendar_irq_clear;
  wire       timer_irq_clear;

  assign wr_prescale = reg_write & (reg_addr == `RTP_OFS_PRESCALE)
                       & ~calendar_enable_lock; // R4 R6
  assign wr_mask     = reg_write & (reg_addr == `RTP_OFS_IRQ_MASK);
  assign wr_clear    = reg_write & (reg_addr == `RTP_OFS_IRQ_CLEAR);
  assign calendar_irq_clear = wr_clear & reg_wdata[`RTP_CAL_BIT]; // R11
  assign timer_irq_clear    = wr_clear & reg_wdata[`RTP_TMR_BIT]; // R12
  assign calendar_irq_masked = calendar_irq_raw & calendar_irq_enable; // R10
  assign timer_irq_masked    = timer_irq_raw & timer_irq_enable; // R10

  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      tick_divider_factor  <= `RTP_DIV_RESET;
      trim_delete_count    <= `RTP_TRIM_RESET;
      calendar_enable_lock <= 1'b0;
      calendar_irq_enable  <= 1'b0;
      timer_irq_enable     <= 1'b0;
    end
    else
    begin
      if (wr_prescale)
      begin
        tick_divider_factor  <= reg_wdata[`RTP_DIV_MSB:`RTP_DIV_LSB]; // R1
        trim_delete_count    <= reg_wdata[`RTP_TRIM_MSB:`RTP_TRIM_LSB]; // R3
        calendar_enable_lock <= reg_wdata[`RTP_LOCK_BIT]; // R5
      end
      if (wr_mask)
      begin
        calendar_irq_enable <= reg_wdata[`RTP_CAL_BIT]; // R7
        timer_irq_enable    <= reg_wdata[`RTP_TMR_BIT]; // R8
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt sources: sticky raw flags and registered lines

  rtp_irq_source i_calendar_source
  (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .event_in (calendar_event),
    .clear_in (calendar_irq_clear),
    .enable   (calendar_irq_enable),
    .raw      (calendar_irq_raw),
    .line     (calendar_irq_line)
  );

  rtp_irq_source i_timer_source
  (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .event_in (timer_event),
    .clear_in (timer_irq_clear),
    .enable   (timer_irq_enable),
    .raw      (timer_irq_raw),
    .line     (timer_irq_line)
  );

  // combined line, same latency as the two source lines
  always @(posedge clk_sys)
  begin
    if (rst)
      irq <= 1'b0;
    else
      irq <= calendar_irq_masked | timer_irq_masked; // R13
  end

  ////////////////////////////////////////////////////////////////////////////
  // read port: data valid the cycle after the strobe

  reg [31:0] next_rdata;

  always @*
  begin
    next_rdata = 32'h00000000;
    case (reg_addr)
      `RTP_OFS_PRESCALE:
      begin
        next_rdata[`RTP_DIV_MSB:`RTP_DIV_LSB]   = tick_divider_factor; // R4
        next_rdata[`RTP_TRIM_MSB:`RTP_TRIM_LSB] = trim_delete_count; // R4
        next_rdata[`RTP_LOCK_BIT]               = calendar_enable_lock; // R6
      end
      `RTP_OFS_IRQ_MASK:
      begin
        next_rdata[`RTP_CAL_BIT] = calendar_irq_enable;
        next_rdata[`RTP_TMR_BIT] = timer_irq_enable;
      end
      `RTP_OFS_IRQ_RAW:
      begin
        next_rdata[`RTP_CAL_BIT] = calendar_irq_raw; // R9
        next_rdata[`RTP_TMR_BIT] = timer_irq_raw; // R9
      end
      `RTP_OFS_IRQ_MASKED:
      begin
        next_rdata[`RTP_CAL_BIT] = calendar_irq_masked; // R10
        next_rdata[`RTP_TMR_BIT] = timer_irq_masked; // R10
      end
      default:
        next_rdata = 32'h00000000;
    endcase
  end

  always @(posedge clk_sys)
  begin
    if (rst)
      reg_rdata <= 32'h00000000;
    else if (reg_read)
      reg_rdata <= next_rdata;
    else
      reg_rdata <= 32'h00000000;
  end

  ////////////////////////////////////////////////////////////////////////////
  // trim: delete the first n slow pulses of each 1023-pulse window

  // deleted pulses come first in the window, so the tick jitters
  // once per window rather than spreading the deletions out
  reg  [TRIM_W-1:0] trim_window;
  reg  [TRIM_W-1:0] trim_deleted;
  wire       trim_drop;
  wire       trimmed_pulse;

  assign trim_drop     = slow_pulse & (trim_deleted < trim_delete_count); // R3
  assign trimmed_pulse = slow_pulse & ~trim_drop;

  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      trim_window  <= 10'h000;
      trim_deleted <= 10'h000;
    end
    else if (slow_pulse)
    begin
      if (trim_window == `RTP_TRIM_WINDOW - 10'h001)
      begin
        trim_window  <= 10'h000; // R3
        trim_deleted <= 10'h000;
      end
      else
      begin
        trim_window <= trim_window + 10'h001;
        if (trim_drop)
          trim_deleted <= trim_deleted + 10'h001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // integer divider

  // divider zero bypasses: the timer sees every kept slow edge and
  // the clockwatch tick stays low
  reg [DIV_W-1:0] div_count;

  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      div_count       <= 15'h0000;
      one_second_tick <= 1'b0;
      timer_tick      <= 1'b0;
    end
    else
    begin
      one_second_tick <= 1'b0;
      timer_tick      <= 1'b0;
      if (trimmed_pulse)
      begin
        if (tick_divider_factor == 15'h0000)
        begin
          div_count  <= 15'h0000;
          timer_tick <= 1'b1; // R2
        end
        else if (div_count >= tick_divider_factor)
        begin
          div_count       <= 15'h0000;
          timer_tick      <= 1'b1;
          one_second_tick <= calendar_enable_lock; // R1 R5
        end
        else
          div_count <= div_count + 15'h0001; // R1
      end
    end
  end

endmodule // rtp_prescaler

////////////////////////////////////////////////////////////////////////////
// one interrupt source: sticky raw flag and registered line

module rtp_irq_source
(
  // clock and reset
  input  wire clk_sys,
  input  wire rst,
  // event, clear and mask
  input  wire event_in,
  input  wire clear_in,
  input  wire enable,
  // raw flag and interrupt line
  output reg  raw,
  output reg  line
);

  // an event in the clearing cycle wins, so no event is lost
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      raw  <= 1'b0;
      line <= 1'b0;
    end
    else
    begin
      if (event_in)
        raw <= 1'b1; // R13
      else if (clear_in)
        raw <= 1'b0; // R11 R12
      // line trails the masked flag by one cycle
      line <= raw & enable; // R13
    end
  end

endmodule // rtp_irq_source

`default_nettype wire

// ==== rtl/rtp_regs.vh ====
// register offsets, field positions and reset values of the rtc prescaler block
`ifndef RTP_REGS_VH
`define RTP_REGS_VH
`define RTP_OFS_PRESCALE     8'h18
`define RTP_OFS_IRQ_MASK     8'h1C
`define RTP_OFS_IRQ_RAW      8'h20
`define RTP_OFS_IRQ_MASKED   8'h24
`define RTP_OFS_IRQ_CLEAR    8'h28
`define RTP_DIV_LSB          0
`define RTP_DIV_MSB          14
`define RTP_TRIM_LSB         16
`define RTP_TRIM_MSB         25
`define RTP_LOCK_BIT         26
`define RTP_CAL_BIT          0
`define RTP_TMR_BIT          1
`define RTP_DIV_RESET        15'h7FFF
`define RTP_TRIM_RESET       10'h000
`define RTP_TRIM_WINDOW      10'h3FF
`endif

// ==== tb/rtp_prescaler_properties.sv ====
// port assertions of the rtc prescaler block
`default_nettype none
module rtp_prescaler_properties
(
  // clock and reset
  input wire logic        clk_sys,
  input wire logic        rst,
  // register port
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_write,
  input wire logic        reg_read,
  input wire logic [31:0] reg_rdata,
  // ticks and lines
  input wire logic        one_second_tick,
  input wire logic        calendar_enable_lock,
  input wire logic        calendar_event,
  input wire logic        calendar_irq_line,
  input wire logic        timer_irq_line,
  input wire logic        irq
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  wire logic wr_clr = reg_write && reg_addr == 8'h28 && reg_wdata[0];
  //////////////////////////////
  AST_RAW_RSV: assert property (reg_read && reg_addr == 8'h20 |=> reg_rdata[31:2] == 30'h0)
    else $error("raw status reserved bits set");
  AST_MSK_RSV: assert property (reg_read && reg_addr == 8'h24 |=> reg_rdata[31:2] == 30'h0)
    else $error("masked status reserved bits set");
  AST_CLR_RD: assert property (reg_read && reg_addr == 8'h28 |=> reg_rdata == 32'h0)
    else $error("clear register readable");
  AST_IRQ_OR: assert property (irq == (calendar_irq_line || timer_irq_line))
    else $error("irq not or of lines");
  AST_LOCK_SET: assert property (reg_write && reg_addr == 8'h18 && reg_wdata[26]
    |=> calendar_enable_lock)
    else $error("lock not set");
  AST_LOCK_HOLD: assert property (calendar_enable_lock |=> calendar_enable_lock)
    else $error("lock dropped");
  AST_TICK_GATE: assert property (!calendar_enable_lock |-> !one_second_tick)
    else $error("tick while disabled");
  AST_TICK_PULSE: assert property (one_second_tick |=> !one_second_tick)
    else $error("tick too long");
  AST_CAL_CLR: assert property (wr_clr && !calendar_event ##1 !calendar_event
    |=> !calendar_irq_line)
    else $error("line survives clear");
  AST_CAL_MASK: assert property (reg_write && reg_addr == 8'h1C && !reg_wdata[0] ##1 !reg_write
    |=> !calendar_irq_line)
    else $error("line while masked");
  cover property (calendar_enable_lock && one_second_tick);
  cover property (irq);
  cover property (wr_clr);
endmodule // rtp_prescaler_properties
bind rtp_prescaler rtp_prescaler_properties i_rtp_prescaler_properties (.*);
`default_nettype wire

// ==== tb/rtp_prescaler_tb_top.sv ====
// self-checking bench of the rtc prescaler block
`default_nettype none
module rtp_prescaler_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_write = 1'b0;
  logic        reg_read = 1'b0;
  logic        slow_clock = 1'b0;
  logic        calendar_event = 1'b0;
  logic        timer_event = 1'b0;
  logic [31:0] reg_rdata;
  logic        one_second_tick, timer_tick, calendar_enable_lock;
  logic        calendar_irq_line, timer_irq_line, irq;
  int          n_fail = 0;
  int          compares = 0;
  int          n_sec, n_tmr;
  // address beside reset value, unmapped last
  logic [39:0] rows [6] = '{40'h18_0000_7FFF, 40'h1C_0000_0000, 40'h20_0000_0000,
                            40'h24_0000_0000, 40'h28_0000_0000, 40'h30_0000_0000};
  rtp_prescaler i_rtp_prescaler (.*);
  initial forever #4 clk_sys = ~clk_sys;
  //////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk_sys);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk_sys);
    reg_read <= 1'b0;
    @(negedge clk_sys);
    chk("reg_rdata", e, reg_rdata);
  endtask
  // slow edges spaced well past the two-flop synchroniser
  task automatic slow(input int n);
    n_sec = 0;
    n_tmr = 0;
    repeat (n)
    begin
      repeat (10) @(posedge clk_sys);
      slow_clock <= 1'b1;
      repeat (10) @(posedge clk_sys);
      slow_clock <= 1'b0;
    end
    repeat (10) @(posedge clk_sys);
  endtask
  task automatic rst_run;
    rst <= 1'b1;
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
  endtask
  always @(posedge clk_sys)
  begin
    if (one_second_tick === 1'b1) n_sec++;
    if (timer_tick === 1'b1) n_tmr++;
  end
  task automatic wrap_up;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    #200000;
    n_fail++;
    wrap_up;
  end
  //////////////////////////////
  initial
  begin
    rst_run;
    foreach (rows[i]) rd(rows[i][39:32], rows[i][31:0]);
    wr(8'h1C, 32'h3);
    rd(8'h1C, 32'h3);
    for (int b = 0; b < 2; b++)
    begin
      @(posedge clk_sys);
      calendar_event <= (b == 0);
      timer_event <= (b == 1);
      @(posedge clk_sys);
      calendar_event <= 1'b0;
      timer_event <= 1'b0;
      rd(8'h20, 32'h1 << b);
      rd(8'h24, 32'h1 << b);
      chk("lines", (32'h2 << b) | 32'h1, {timer_irq_line, calendar_irq_line, irq});
      wr(8'h28, 32'h0);
      rd(8'h20, 32'h1 << b);
      wr(8'h1C, 32'h0);
      rd(8'h24, 32'h0);
      chk("lines", 32'h0, {timer_irq_line, calendar_irq_line, irq});
      wr(8'h28, 32'h1 << b);
      rd(8'h20, 32'h0);
      wr(8'h1C, 32'h3);
    end
    wr(8'h18, 32'h0);
    rd(8'h18, 32'h0);
    wr(8'h18, 32'h0400_0000);
    slow(4);
    chk("timer_ticks", 32'h4, n_tmr);
    chk("second_ticks", 32'h0, n_sec);
    rst_run;
    chk("lock", 32'h0, calendar_enable_lock);
    wr(8'h18, 32'h1);
    wr(8'h18, 32'h0400_0001);
    wr(8'h18, 32'h0003_0005);
    rd(8'h18, 32'h0400_0001);
    slow(8);
    chk("second_ticks", 32'h4, n_sec);
    rst_run;
    wr(8'h18, 32'h0002_0000);
    slow(4);
    chk("trim_ticks", 32'h2, n_tmr);
    wrap_up;
  end
endmodule // rtp_prescaler_tb_top
`default_nettype wire
